/* File: logic/crbs_consts.svh */
`ifndef CRBS_CONSTS_SVH
`define CRBS_CONSTS_SVH
// ready line levels on the shared wired-and net
`define CRBS_READY_TRUE  1'b1
`define CRBS_READY_FALSE 1'b0
// status codes reported to the query port
`define CRBS_ST_MONITOR  2'h0
`define CRBS_ST_WAIT     2'h1
`define CRBS_ST_RUN      2'h2
`endif

/* File: logic/crbs_pkg.sv */
package crbs_pkg;
   // run-control state of one unit
   typedef enum logic [1:0] {
      CRBS_MONITOR,
      CRBS_WAIT,
      CRBS_RUN
   } crbs_state_t;

   // local requests from the unit's own command layer
   typedef struct packed {
      logic runReq;
      logic breakReq;
      logic resetReq;
      logic execReq;
   } crbs_req_t;

   // status bundle shown by the emulation status query
   typedef struct packed {
      logic [1:0] code;
      logic       running;
      logic       waitReady;
      logic       inMonitor;
   } crbs_status_t;
endpackage : crbs_pkg

/* File: logic/coordinated_run_break_sync.sv */
`timescale 1ns/1ps
`include "crbs_consts.svh"

// How it works
// - without participation enable the unit ignores the bus inputs and releases ready, but still drives execute requests
// - run request while ready is low waits and reports waiting-for-ready
// - when the last stopped unit releases ready all participants run together
// - a break on any participant stops it, and every other participant one cycle later
// - the breaking unit sits in monitor, all others in wait
// - run on the monitor unit releases ready and restarts everyone
// - running unit enabled while ready is low breaks to monitor, waits to resume
// - unit held by ready starts as soon as the holding peer runs
// - running unit enabled while ready is high keeps running
// - break on a non-participant leaves participating peers running
// - monitor unit that becomes a participant pulls ready low
// - participant drives ready low on break or reset until ready to run
// - non-participant releases ready (never pulls it) and ignores execute
module coordinated_run_break_sync
   import crbs_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         cmbEnable,
   input  wire crbs_req_t    req,
   input  wire logic         readyIn,
   output logic              readyOut,
   output logic              readyOe,
   input  wire logic         executeIn,
   output logic              executeOut,
   output logic              executeOe,
   output logic              userRun,
   output crbs_status_t      emulation_status_query
);

   ////////////////////////////////////////////////////////////////////////////
   // how the shared lines are used
   //
   // the ready net is wired-and: every attached unit may pull it low, and
   // it only reads true when nobody pulls. a participating unit pulls it
   // while it sits unarmed in its monitor, so a run request on any one unit cannot
   // start the group until every stopped participant has been asked to run.
   //
   // a running participant that sees ready low drops to the wait state and
   // leaves the net alone; it resumes on its own once ready returns, which
   // is how a break on one unit stops the others and a run restarts them.
   //
   // a unit that joins while running and finds ready low goes to monitor
   // but does not pull: it is armed to resume, and starts as soon as the
   // peer that holds ready low begins to run. pulling here would deadlock
   // the group, since this unit would then hold ready low itself.
   //
   // the execute net is an active-high pulse; in monitor it acts like a
   // local run request. a non-participant ignores both nets as inputs, yet still pulses execute on request.
   //
   // hazard: ready and execute are sampled directly on the clock, so the
   // bus side must present them synchronous to clk.

   ////////////////////////////////////////////////////////////////////////////
   // state registers
   crbs_state_t  state_ff;
   crbs_state_t  nxt_state;
   logic         pullLow_ff;
   logic         nxt_pullLow;
   logic         execOe_ff;
   logic         nxt_execOe;
   logic         userRun_ff;
   logic         nxt_userRun;
   crbs_status_t status_ff;
   crbs_status_t nxt_status;
   logic         enPrev_ff;                                // enable seen last cycle
   logic         nxt_enPrev;
   logic         resume_ff;                                // monitor armed to resume
   logic         nxt_resume;
   logic         enRise;                                   // participation just enabled

   ////////////////////////////////////////////////////////////////////////////
   // run-control next state
   always_comb begin
      nxt_state   = state_ff;
      nxt_pullLow = pullLow_ff;
      nxt_resume  = resume_ff;
      nxt_enPrev  = cmbEnable;
      nxt_execOe  = req.execReq;                           // one-cycle execute pulse
      enRise      = cmbEnable && !enPrev_ff;
      if (req.resetReq) begin
         nxt_state   = CRBS_MONITOR;
         nxt_pullLow = cmbEnable;
         nxt_resume  = 1'b0;
      end else if (!cmbEnable) begin
         // standalone: bus and execute ignored
         nxt_pullLow = 1'b0;
         nxt_resume  = 1'b0;
         if (req.breakReq) begin
            nxt_state = CRBS_MONITOR;
         end else if (req.runReq && state_ff != CRBS_RUN) begin
            nxt_state = CRBS_RUN;
         end else if (state_ff == CRBS_WAIT) begin
            nxt_state = CRBS_MONITOR;
         end
      end else begin
         unique case (state_ff)
            CRBS_RUN: begin
               if (req.breakReq) begin
                  nxt_state   = CRBS_MONITOR;
                  nxt_pullLow = 1'b1;
               end else if (readyIn == `CRBS_READY_FALSE) begin
                  if (enRise) begin
                     // just joined a stopped group: monitor, armed, not pulling
                     nxt_state   = CRBS_MONITOR;
                     nxt_pullLow = 1'b0;
                     nxt_resume  = 1'b1;
                  end else begin
                     // peer break or newly enabled monitor peer pulling ready low
                     nxt_state   = CRBS_WAIT;
                  end
               end                                         // ready high keeps running
            end
            CRBS_MONITOR: begin
               if (req.breakReq) begin
                  // break outranks run and cancels any armed resume
                  nxt_pullLow = 1'b1;
                  nxt_resume  = 1'b0;
               end else if (req.runReq || executeIn) begin
                  nxt_pullLow = 1'b0;
                  nxt_state   = CRBS_WAIT;
                  nxt_resume  = 1'b0;
               end else if (resume_ff) begin
                  // armed: leave ready alone, start once the holder runs
                  nxt_pullLow = 1'b0;
                  if (readyIn == `CRBS_READY_TRUE) begin
                     nxt_state  = CRBS_RUN;
                     nxt_resume = 1'b0;
                  end
               end else begin
                  nxt_pullLow = 1'b1;
               end
            end
            CRBS_WAIT: begin
               if (req.breakReq) begin
                  nxt_state   = CRBS_MONITOR;
                  nxt_pullLow = 1'b1;
               end else if (!pullLow_ff && readyIn == `CRBS_READY_TRUE) begin
                  nxt_state = CRBS_RUN;
               end
            end
         endcase
      end
   end

   // registers for state, ready drive and execute drive
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff   <= CRBS_MONITOR;
         pullLow_ff <= 1'b0;
         execOe_ff  <= 1'b0;
         enPrev_ff  <= 1'b0;
         resume_ff  <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         pullLow_ff <= nxt_pullLow;
         execOe_ff  <= nxt_execOe;
         enPrev_ff  <= nxt_enPrev;
         resume_ff  <= nxt_resume;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status and user-run outputs
   always_comb begin
      nxt_userRun          = (nxt_state == CRBS_RUN);
      nxt_status.running   = (nxt_state == CRBS_RUN);
      nxt_status.waitReady = (nxt_state == CRBS_WAIT);
      nxt_status.inMonitor = (nxt_state == CRBS_MONITOR);
      unique case (nxt_state)
         CRBS_RUN:  nxt_status.code = `CRBS_ST_RUN;
         CRBS_WAIT: nxt_status.code = `CRBS_ST_WAIT;
         default:   nxt_status.code = `CRBS_ST_MONITOR;
      endcase
   end

   // registers for status outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         userRun_ff <= 1'b0;
         status_ff  <= '{code: `CRBS_ST_MONITOR, running: 1'b0, waitReady: 1'b0,
                         inMonitor: 1'b1};
      end else begin
         userRun_ff <= nxt_userRun;
         status_ff  <= nxt_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // open-drain pins: ready level always low, execute level always high, enable drives the net.
   // the data levels are fixed, so only the enables ever move; the ready
   // enable comes from its own register and never glitches between
   // edges, which matters because every peer samples the same net.
   // the execute enable is high for exactly one cycle per request, and
   // a unit sees its own pulse on the net like any peer does.
   assign readyOut               = `CRBS_READY_FALSE;
   assign readyOe                = pullLow_ff;
   assign executeOut             = 1'b1;
   assign executeOe              = execOe_ff;
   assign userRun                = userRun_ff;
   assign emulation_status_query = status_ff;

endmodule : coordinated_run_break_sync

/* File: tb/crbs_chk_asserts.sv */
`timescale 1ns/1ps
////////////////////////////////////////
// watches run and break coordination
module crbs_chk
   import crbs_pkg::*;
(
   input wire logic         clk,
   input wire logic         rst_b,
   input wire logic         cmbEnable,
   input wire crbs_req_t    req,
   input wire logic         readyIn,
   input wire logic         readyOut,
   input wire logic         readyOe,
   input wire logic         executeIn,
   input wire logic         userRun,
   input wire crbs_status_t emulation_status_query
);
   logic [1:0] st;
   logic       calm;
   logic       on;
   // status code and request shorthand
   assign st = emulation_status_query.code;
   assign calm = !req.breakReq && !req.resetReq;
   assign on = cmbEnable && calm;
   logic       enPrev;
   logic       armSeen;
   // tracks a unit that joined while running on a low ready net
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         enPrev  <= 1'b0;
         armSeen <= 1'b0;
      end else begin
         enPrev <= cmbEnable;
         if (cmbEnable && !enPrev && userRun && !readyIn && calm) armSeen <= 1'b1;
         else if (!cmbEnable || !calm || req.runReq || executeIn || readyIn) armSeen <= 1'b0;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_ready_od: assert property (readyOut == 1'b0)
      else $error("ready data high");
   a_off_free: assert property (!cmbEnable |=> !readyOe)
      else $error("idle unit pulls");
   a_run_wait: assert property (on && req.runReq && st == 2'h0
      |=> st == 2'h1 && !userRun && !readyOe) else $error("no wait");
   a_brk_mon: assert property (cmbEnable && req.breakReq && !req.resetReq
      |=> st == 2'h0 && readyOe && !userRun) else $error("no monitor");
   a_low_stop: assert property (on && userRun && !readyIn |=> !userRun)
      else $error("ran on low");
   a_go_ready: assert property (on && st == 2'h1 && readyIn
      |=> userRun && st == 2'h2) else $error("no start");
   a_keep_run: assert property (on && userRun && readyIn |=> userRun)
      else $error("run lost");
   a_mon_pull: assert property (cmbEnable && st == 2'h0 && !req.runReq
      && !executeIn && !armSeen |=> readyOe) else $error("no pull");
   a_join_brk: assert property (cmbEnable && !enPrev && userRun && !readyIn
      && calm |=> st == 2'h0 && !userRun && !readyOe) else $error("no join break");
   a_resume_go: assert property (armSeen && on && readyIn && !req.runReq
      && !executeIn |=> userRun) else $error("no resume");
   cover property (armSeen && readyIn);
   cover property (st == 2'h1 && cmbEnable);
   cover property (userRun && cmbEnable);
   cover property (req.breakReq && userRun);
endmodule : crbs_chk

/* File: tb/crbs_peer.sv */
`timescale 1ns/1ps
// peer unit: pulls the wired-and ready net low
module crbs_peer (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic hold,
   output logic      pullLow_ff
);
   // registered pull, open drain
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) pullLow_ff <= 1'b1;
      else pullLow_ff <= hold;
   end
endmodule : crbs_peer

/* File: tb/coordinated_run_break_sync_test.sv */
`timescale 1ns/1ps
module coordinated_run_break_sync_test;
   import crbs_pkg::*;
   logic clk, rst_b, en, hold, pull, oe, exOe, run;
   crbs_req_t req;
   crbs_status_t sq;
   int fail_count, num_checks;
   coordinated_run_break_sync u_dut (.clk(clk), .rst_b(rst_b), .cmbEnable(en),
      .req(req), .readyIn(!(oe | pull)), .readyOut(), .readyOe(oe), .executeIn(exOe),
      .executeOut(), .executeOe(exOe), .userRun(run), .emulation_status_query(sq));
   crbs_peer u_peer (.clk(clk), .rst_b(rst_b), .hold(hold), .pullLow_ff(pull));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task step(int n); repeat (n) @(posedge clk); #1; endtask : step
   // compares {run, status code, pull}
   task chk(logic [3:0] e);
      num_checks++;
      if ({run, sq.code, oe} !== e) begin
         fail_count++;
         $display("[FAIL] %0t got %h want %h", $time, {run, sq.code, oe}, e);
      end
   endtask : chk
   // compares the execute drive
   task chkExec(logic e);
      num_checks++;
      if (exOe !== e) begin
         fail_count++;
         $display("[FAIL] %0t execute got %b want %b", $time, exOe, e);
      end
   endtask : chkExec
   task pulse(crbs_req_t r); req = r; step(1); req = '0; endtask : pulse
   task t_off;
      en = 1'b0;
      pulse(4'h8); step(1); chk(4'hc);
      hold = 1'b0; step(1);
      en = 1'b1; step(2); chk(4'hc);
      en = 1'b0; pulse(4'h4); chk(4'h0);
      $display("t_off done");
   endtask : t_off
   task t_sync;
      hold = 1'b1; en = 1'b1; step(2); chk(4'h1);
      pulse(4'h8); step(1); chk(4'h2);
      hold = 1'b0; step(2); chk(4'hc);
      $display("t_sync done");
   endtask : t_sync
   task t_brk;
      hold = 1'b1; step(2); chk(4'h2);
      hold = 1'b0; step(2); chk(4'hc);
      pulse(4'h4); chk(4'h1);
      pulse(4'h8); step(1); chk(4'hc);
      en = 1'b0; hold = 1'b1; step(2); chk(4'hc);
      en = 1'b1; step(1); chk(4'h0);
      hold = 1'b0; step(2); chk(4'hc);
      pulse(4'h4); chk(4'h1);
      pulse(4'h1); chkExec(1'b1);
      step(1); chkExec(1'b0);
      step(1); chk(4'hc);
      $display("t_brk done");
   endtask : t_brk
   task finish_test;
      $display("checks %0d fails %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      rst_b = 1'b0; en = 1'b0; hold = 1'b1; req = '0;
      repeat (12) @(posedge clk);
      #1 rst_b = 1'b1;
      step(1); t_off; t_sync; t_brk;
      finish_test;
   end
   // watchdog, far beyond the run's few hundred ns
   initial begin
      #20000;
      fail_count++;
      finish_test;
   end
endmodule : coordinated_run_break_sync_test
bind coordinated_run_break_sync crbs_chk u_chk (.*);
